// ===== src/scq_pkg.sv
// Purpose: constants and carriers for the serial channel queue configuration block
// Assumes: 32-bit register port, one word per register
// Notes: offsets are byte addresses
package scq_pkg;
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_RX_CFG = 8'h04;
  localparam logic [7:0] OFF_RX_STAT = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_TX_LVL = 8'h18;
  // setup register fields
  localparam int SETUP_ENABLE_BIT = 0;
  localparam int SETUP_AUTO_BIT = 1;
  localparam int SETUP_RXIE_BIT = 2;
  // rx config fields
  localparam int RXC_CLEAR_BIT = 7;
  localparam int RXC_COND_BIT = 6;
  localparam int RXC_THR_LSB = 0;
  // mode register fields
  localparam int MODE_RXE_BIT = 0;
  localparam int MODE_TXE_BIT = 1;
  localparam int MODE_DPX_LSB = 2;
  // irq status fields
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_AUTO_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] QUEUE_DEPTH = 3'h4;
  localparam logic [2:0] HALF_DEPTH = 3'h2;
  localparam logic [2:0] LVL_EMPTY = 3'h0;
  typedef enum logic [1:0] {SCQ_DPX_OFF, SCQ_DPX_HALF_RX, SCQ_DPX_HALF_TX, SCQ_DPX_FULL} scq_dpx_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scq_bus_t;
  typedef struct packed {
    logic rx_shift_full;
    logic rx_buf_full;
    logic tx_buf_empty;
    logic tx_shift_empty;
  } scq_link_t;
endpackage : scq_pkg

// ===== src/scq_top.sv
// Purpose: receive queue, queue sizing and auto enable clearing for one serial channel
// Assumes: link side strobes are one-cycle pulses synchronous to clk_sys
// Notes: transmit queue occupancy is supplied by the transmit side
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - In half-duplex receive with auto clear and the queue both on, the receive enable drops once shift register, buffer and queue are all full.
// - In half-duplex transmit with auto clear on, the transmit enable drops once queue, buffer and shift register are all empty.
// - In full duplex with auto clear on, either condition drops both enables, the receive one only while the queue is on.
// - The queue enable bit turns the queues off at 0 and on at 1, leaving only the plain buffers when off.
// - Queue size follows duplex: 4 receive, 4 transmit, or 2 plus 2.
// - The transmit queue offers 4 bytes in half-duplex transmit, 2 in full duplex and none otherwise; its occupancy is the bytes written and not yet sent.
// - Writing 1 to bit 7 of the receive config empties the receive queue, zeroes its level and resets the read pointer.
// - Condition bit 0 raises the interrupt on reaching the threshold, 1 also when above it at a read.
// - Threshold codes 00..11 mean 4,1,2,3 bytes in half duplex and 2,1,2,1 in full duplex.
// - A threshold interrupt never raises a transfer request.
// - Auto clear bit 1 of the setup register leaves enables alone at 0 and clears them automatically at 1.
// - With the queue on, the receive interrupt enable gates receive interrupts.
// - The receive level status reads occupancy from 000 to 100.
module scq_top
  import scq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire scq_bus_t bus,
  output logic [31:0] rdata,
  // link side
  input wire scq_link_t link,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_pop,
  input wire logic [2:0] tx_level,
  // controls and outputs
  output logic rx_enable,
  output logic tx_enable,
  output logic [7:0] rx_data,
  output logic rx_queue_full,
  output logic [2:0] rx_capacity,
  output logic [2:0] tx_capacity,
  output logic dma_req,
  output logic irq
);

  logic [31:0] queue_setup_register;
  logic [31:0] rx_queue_config;
  logic [31:0] channel_mode_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [7:0] mem_reg [0:3];
  logic [1:0] wptr_reg;
  logic [1:0] rptr_reg;
  logic [2:0] level_reg;
  logic [2:0] cap_next;
  logic [2:0] thr_next;
  logic [1:0] dpx;
  logic q_on;
  logic rx_clear;
  logic push;
  logic pop;
  logic rx_all_full;
  logic tx_all_empty;
  logic auto_hit;
  logic rx_evt;
  logic ovr_evt;
  logic [2:0] level_next;
  logic [IRQ_W-1:0] evt;
  logic [2:0] tx_cap_next;
  logic [31:0] rdata_next;
  logic wr_setup;
  logic wr_rx_cfg;
  logic wr_mode;
  logic wr_irq_stat;
  logic wr_irq_mask;

  assign dpx = channel_mode_reg[MODE_DPX_LSB +: 2];
  assign q_on = queue_setup_register[SETUP_ENABLE_BIT];
  assign rx_clear = wr_rx_cfg && bus.wdata[RXC_CLEAR_BIT];
  // register write strobes
  assign wr_setup = bus.wr && bus.addr == OFF_SETUP;
  assign wr_rx_cfg = bus.wr && bus.addr == OFF_RX_CFG;
  assign wr_mode = bus.wr && bus.addr == OFF_MODE;
  assign wr_irq_stat = bus.wr && bus.addr == OFF_IRQ_STAT;
  assign wr_irq_mask = bus.wr && bus.addr == OFF_IRQ_MASK;

  // queue sizing from duplex
  always_comb begin
    cap_next = 3'h0;
    if (q_on) begin
      if (dpx == SCQ_DPX_HALF_RX) begin
        cap_next = QUEUE_DEPTH;
      end else if (dpx == SCQ_DPX_FULL) begin
        cap_next = HALF_DEPTH;
      end
    end
  end

  // transmit queue size offered to the transmit side
  always_comb begin
    tx_cap_next = 3'h0;
    if (q_on) begin
      if (dpx == SCQ_DPX_HALF_TX) begin
        tx_cap_next = QUEUE_DEPTH;
      end else if (dpx == SCQ_DPX_FULL) begin
        tx_cap_next = HALF_DEPTH;
      end
    end
  end

  // threshold decode
  always_comb begin
    case (rx_queue_config[RXC_THR_LSB +: 2])
      2'h0: thr_next = (dpx == SCQ_DPX_FULL) ? 3'h2 : 3'h4;
      2'h1: thr_next = 3'h1;
      2'h2: thr_next = 3'h2;
      default: thr_next = (dpx == SCQ_DPX_FULL) ? 3'h1 : 3'h3;
    endcase
  end

  assign push = rx_byte_valid && q_on && rx_enable && level_reg < cap_next;
  assign pop = rx_pop && level_reg != LVL_EMPTY;
  assign ovr_evt = rx_byte_valid && q_on && rx_enable && level_reg >= cap_next;
  assign level_next = 3'(level_reg + {2'h0, push} - {2'h0, pop});
  // reach on push, or above threshold at a read when condition is 1
  assign rx_evt = q_on && queue_setup_register[SETUP_RXIE_BIT] &&
    ((push && level_next == thr_next) ||
     (rx_queue_config[RXC_COND_BIT] && pop && level_next > thr_next));
  assign rx_all_full = link.rx_shift_full && link.rx_buf_full && level_reg >= cap_next
    && cap_next != 3'h0;
  assign tx_all_empty = tx_level == LVL_EMPTY && link.tx_buf_empty && link.tx_shift_empty;
  always_comb begin
    auto_hit = 1'b0;
    if (queue_setup_register[SETUP_AUTO_BIT]) begin
      case (dpx)
        SCQ_DPX_HALF_RX: auto_hit = rx_all_full && rx_enable;
        SCQ_DPX_HALF_TX: auto_hit = tx_all_empty && tx_enable;
        SCQ_DPX_FULL: auto_hit = (rx_all_full || tx_all_empty) && (rx_enable || tx_enable);
        default: auto_hit = 1'b0;
      endcase
    end
  end
  assign evt = {ovr_evt, auto_hit, rx_evt};

  // setup register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      queue_setup_register <= RESET_WORD;
    end else if (wr_setup) begin
      queue_setup_register <= {29'h0, bus.wdata[2:0]};
    end
  end

  // receive config, clear bit is not stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_queue_config <= RESET_WORD;
    end else if (wr_rx_cfg) begin
      rx_queue_config <= {25'h0, bus.wdata[RXC_COND_BIT], 4'h0, bus.wdata[1:0]};
    end
  end

  // mode register with auto clearing of enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_mode_reg <= RESET_WORD;
    end else if (wr_mode) begin
      channel_mode_reg <= {28'h0, bus.wdata[3:0]};
    end else if (auto_hit) begin
      if (dpx != SCQ_DPX_HALF_TX) begin
        channel_mode_reg[MODE_RXE_BIT] <= 1'b0;
      end
      if (dpx != SCQ_DPX_HALF_RX) begin
        channel_mode_reg[MODE_TXE_BIT] <= 1'b0;
      end
    end
  end

  // receive queue storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wptr_reg] <= rx_byte;
    end
  end

  // pointers and level
  always_ff @(posedge clk_sys) begin
    if (rst || rx_clear || !q_on) begin
      wptr_reg <= 2'h0;
      rptr_reg <= 2'h0;
      level_reg <= LVL_EMPTY;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg + 2'h1) & 2'(cap_next - 3'h1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg + 2'h1) & 2'(cap_next - 3'h1);
      end
      level_reg <= level_next;
    end
  end

  // sticky status per bit, set wins over clear
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq_bit
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        irq_stat_reg[i] <= 1'b0;
      end else if (evt[i]) begin
        irq_stat_reg[i] <= 1'b1;
      end else if (wr_irq_stat && bus.wdata[i]) begin
        irq_stat_reg[i] <= 1'b0;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= bus.wdata[IRQ_W-1:0];
    end
  end

  // channel enables, auto clear applied on the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      rx_enable <= channel_mode_reg[MODE_RXE_BIT] && !(auto_hit && dpx != SCQ_DPX_HALF_TX);
      tx_enable <= channel_mode_reg[MODE_TXE_BIT] && !(auto_hit && dpx != SCQ_DPX_HALF_RX);
    end
  end

  // head byte and full flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_data <= 8'h00;
      rx_queue_full <= 1'b0;
    end else begin
      rx_data <= mem_reg[rptr_reg];
      rx_queue_full <= level_next == cap_next && cap_next != 3'h0;
    end
  end

  // sizes seen by the link side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_capacity <= 3'h0;
      tx_capacity <= 3'h0;
    end else begin
      rx_capacity <= cap_next;
      tx_capacity <= tx_cap_next;
    end
  end

  // interrupt line, threshold events never request transfers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dma_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      dma_req <= 1'b0;
      irq <= |((irq_stat_reg | evt) & irq_mask_reg);
    end
  end

  // register read mux
  always_comb begin
    rdata_next = RESET_WORD;
    if (bus.addr == OFF_SETUP) begin
      rdata_next = queue_setup_register;
    end else if (bus.addr == OFF_RX_CFG) begin
      rdata_next = rx_queue_config;
    end else if (bus.addr == OFF_RX_STAT) begin
      rdata_next = {29'h0, level_reg};
    end else if (bus.addr == OFF_MODE) begin
      rdata_next = channel_mode_reg;
    end else if (bus.addr == OFF_IRQ_STAT) begin
      rdata_next = {29'h0, irq_stat_reg};
    end else if (bus.addr == OFF_IRQ_MASK) begin
      rdata_next = {29'h0, irq_mask_reg};
    end else if (bus.addr == OFF_TX_LVL) begin
      rdata_next = {29'h0, tx_level};
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= RESET_WORD;
    end else if (bus.rd) begin
      rdata <= rdata_next;
    end
  end

endmodule : scq_top
`default_nettype wire

// ===== tb/scq_peer.sv
// Purpose: shift registers and remote peer of the channel
// Assumes: push and pop are one-cycle commands
// Notes: tx side drains one byte a cycle once unloaded
`timescale 1ns/1ps
`default_nettype none
module scq_peer
  import scq_pkg::*;
(
  // clock and commands
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] din,
  input wire logic rx_hold,
  input wire logic [2:0] tx_fill,
  // toward the block
  output scq_link_t link,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_pop,
  output logic [2:0] tx_level
);
  always_ff @(posedge clk_sys) begin
    rx_byte_valid <= push & ~rst;
    rx_byte <= (push | rst) ? din : ~rx_byte;
    rx_pop <= pop & ~rst;
    // occupancy is what software wrote and not yet sent
    tx_level <= rst ? 3'h0 : (tx_fill != 3'h0) ? tx_fill : tx_level - {2'h0, |tx_level};
  end
  assign link = '{rx_hold, rx_hold, tx_level == 3'h0, tx_level == 3'h0};
endmodule : scq_peer
`default_nettype wire

// ===== tb/scq_sva.sv
// Purpose: port checks for the channel queue block
// Assumes: one clock, synchronous reset
// Notes: bound to scq_top
`timescale 1ns/1ps
`default_nettype none
module scq_sva
  import scq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire scq_bus_t bus,
  input wire logic [31:0] rdata,
  // link side
  input wire scq_link_t link,
  input wire logic [2:0] tx_level,
  // outputs
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire logic rx_queue_full,
  input wire logic [2:0] rx_capacity,
  input wire logic [2:0] tx_capacity,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic mode_wr = bus.wr && bus.addr == OFF_MODE;
  wire logic rx_full_c = link.rx_shift_full && link.rx_buf_full && rx_queue_full;
  wire logic tx_empty_c = tx_level == 3'h0 && link.tx_buf_empty && link.tx_shift_empty;
  dma_quiet_a: assert property (dma_req == 1'b0) else $error("dma request raised");
  cap_split_a: assert property (rx_capacity == 3'h0 || tx_capacity == 3'h0 ||
    (rx_capacity == 3'h2 && tx_capacity == 3'h2)) else $error("bad capacity split");
  cap_value_a: assert property (rx_capacity inside {3'h0, 3'h2, 3'h4} &&
    tx_capacity inside {3'h0, 3'h2, 3'h4}) else $error("bad capacity value");
  cfg_read_a: assert property (bus.rd && bus.addr == OFF_RX_CFG |=>
    rdata[31:7] == 25'h0 && rdata[5:2] == 4'h0) else $error("rx config reserved bits");
  lvl_read_a: assert property (bus.rd && bus.addr == OFF_RX_STAT |=>
    rdata[31:3] == 29'h0 && rdata[2:0] <= 3'h4) else $error("rx level out of range");
  clear_empty_a: assert property (bus.wr && bus.addr == OFF_RX_CFG &&
    bus.wdata[RXC_CLEAR_BIT] && rx_capacity != 3'h0 |=> ##1 !rx_queue_full)
    else $error("queue full after clear");
  enable_rise_a: assert property ($rose(rx_enable) || $rose(tx_enable) |-> $past(mode_wr, 2))
    else $error("enable rose without write");
  rx_drop_a: assert property ($fell(rx_enable) && !$past(mode_wr, 2) && !$past(rst) |->
    $past(rx_full_c || tx_empty_c)) else $error("rx enable dropped without cause");
  tx_drop_a: assert property ($fell(tx_enable) && !$past(mode_wr, 2) && !$past(rst) |->
    $past(rx_full_c || tx_empty_c)) else $error("tx enable dropped without cause");
  cover property ($fell(rx_enable));
  cover property ($fell(tx_enable));
  cover property ($rose(irq));
endmodule : scq_sva
bind scq_top scq_sva chk (.clk_sys, .rst, .bus, .rdata, .link, .tx_level, .rx_enable,
  .tx_enable, .rx_queue_full, .rx_capacity, .tx_capacity, .dma_req, .irq);
`default_nettype wire

// ===== tb/scq_top_tb.sv
// Purpose: self-checking bench for the channel queue block
// Assumes: peer model drives the link side
// Notes: reads are scored against a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module scq_top_tb;
  import scq_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, push = 1'b0, pop = 1'b0, rx_hold = 1'b0, rd_d = 1'b0;
  scq_bus_t bus = '0;
  logic [7:0] din = 8'h00, rx_data, rx_byte;
  logic [2:0] tx_fill = 3'h0, rx_capacity, tx_capacity, tx_level;
  logic [31:0] rdata, w, want[$];
  logic rx_enable, tx_enable, rx_queue_full, dma_req, irq, rx_byte_valid, rx_pop;
  scq_link_t link;
  int fail_count = 0, checked = 0, cycles = 0;
  int thr[8] = '{4, 1, 2, 3, 2, 1, 2, 1};
  always #2 clk_sys = ~clk_sys;
  scq_top dut (.clk_sys, .rst, .bus, .rdata, .link, .rx_byte_valid, .rx_byte, .rx_pop,
    .tx_level, .rx_enable, .tx_enable, .rx_data, .rx_queue_full, .rx_capacity,
    .tx_capacity, .dma_req, .irq);
  scq_peer peer (.clk_sys, .rst, .push, .pop, .din, .rx_hold, .tx_fill, .link,
    .rx_byte_valid, .rx_byte, .rx_pop, .tx_level);
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic wr);
    @(posedge clk_sys);
    bus <= '{a, d, wr, ~wr};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    want.push_back(e);
    acc(a, 32'h0, 1'b0);
  endtask : rd
  task automatic link_op(input logic u, input logic [7:0] b);
    @(posedge clk_sys);
    push <= u;
    pop <= ~u;
    din <= b;
    @(posedge clk_sys);
    push <= 1'b0;
    pop <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : link_op
  always @(posedge clk_sys) begin
    rd_d <= bus.rd;
    cycles <= cycles + 1;
    if (rd_d) cmp_word(rdata, want.pop_front());
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  // plain 8-bit mode, no interrupt-paced transfers, so the queue may be used
  initial begin
    void'($urandom(81096));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_RX_CFG, RESET_WORD);
    w = $urandom;
    acc(OFF_RX_CFG, w & 32'hffff_ff7f, 1'b1);
    rd(OFF_RX_CFG, w & 32'h43);
    rd(8'h1c, 32'h0);
    for (int m = 0; m < 8; m++) begin
      acc(OFF_MODE, (m < 4) ? 32'h5 : 32'hf, 1'b1);
      acc(OFF_SETUP, 32'h5, 1'b1);
      acc(OFF_RX_CFG, 32'h80 | 32'(m % 4), 1'b1);
      rd(OFF_RX_STAT, 32'h0);
      acc(OFF_IRQ_STAT, 32'h7, 1'b1);
      acc(OFF_IRQ_MASK, 32'h1, 1'b1);
      cmp_word({29'h0, rx_capacity}, (m < 4) ? 32'h4 : 32'h2);
      for (int k = 1; k <= thr[m]; k++) begin
        cmp_bit(irq, 1'b0);
        link_op(1'b1, 8'(k * 49));
      end
      cmp_bit(irq, 1'b1);
      cmp_word({24'h0, rx_data}, 32'h31);
      rd(OFF_RX_STAT, 32'(thr[m]));
      acc(OFF_IRQ_STAT, 32'h1, 1'b1);
      cmp_bit(irq, 1'b0);
    end
    for (int c = 0; c < 2; c++) begin
      acc(OFF_MODE, 32'h5, 1'b1);
      acc(OFF_RX_CFG, 32'h81 | 32'(c << 6), 1'b1);
      repeat (3) link_op(1'b1, 8'($urandom));
      acc(OFF_IRQ_STAT, 32'h1, 1'b1);
      link_op(1'b0, 8'h00);
      cmp_bit(irq, c[0]);
    end
    acc(OFF_SETUP, 32'h7, 1'b1);
    acc(OFF_RX_CFG, 32'h80, 1'b1);
    repeat (4) link_op(1'b1, 8'h00);
    cmp_bit(rx_queue_full, 1'b1);
    cmp_bit(rx_enable, 1'b1);
    rx_hold <= 1'b1;
    link_op(1'b1, 8'h00);
    cmp_bit(rx_enable, 1'b0);
    rx_hold <= 1'b0;
    for (int a = 0; a < 2; a++) begin
      tx_fill <= 3'h3;
      acc(OFF_SETUP, 32'h1 | 32'(a << 1), 1'b1);
      acc(OFF_MODE, 32'ha, 1'b1);
      cmp_word({29'h0, tx_capacity}, 32'h4);
      tx_fill <= 3'h0;
      link_op(1'b0, 8'h00);
      cmp_bit(tx_enable, ~a[0]);
    end
    tx_fill <= 3'h3;
    acc(OFF_MODE, 32'hf, 1'b1);
    cmp_bit(rx_enable, 1'b1);
    tx_fill <= 3'h0;
    link_op(1'b0, 8'h00);
    cmp_bit(rx_enable, 1'b0);
    cmp_bit(tx_enable, 1'b0);
    acc(OFF_SETUP, 32'h0, 1'b1);
    cmp_word({26'h0, rx_capacity, tx_capacity}, 32'h0);
    wrap_up();
  end
endmodule : scq_top_tb
`default_nettype wire
